// ### design/adddp_core.sv
// add instruction execution datapath with registers and indicators
`timescale 1ns/1ps
`default_nettype none
module adddp_core #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // instruction from sequencer
    input wire logic start,
    input wire adddp_pkg::adddp_req_type req,
    output logic busy,
    output logic done,
    output adddp_pkg::adddp_check_type check,
    output adddp_pkg::adddp_flags_type flags,
    // main storage
    output logic memReq,
    output logic memWrite,
    output logic memByte,
    output logic [15:0] memAddr,
    output logic [WIDTH-1:0] memWdata,
    input wire logic memAck,
    input wire logic [WIDTH-1:0] memRdata,
    input wire logic memUnassigned,
    input wire logic memReadOnly,
    // software port
    input wire logic [3:0] swAddr,
    input wire logic [15:0] swWdata,
    input wire logic swWrite,
    input wire logic swRead,
    output logic [15:0] swRdata,
    output logic irq
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CHECK = 3'b001,
        S_READ = 3'b010,
        S_WRITE = 3'b011,
        S_COMMIT = 3'b100
    } adddp_state_type;

    adddp_state_type state_q;
    adddp_pkg::adddp_req_type req_q;
    logic [WIDTH-1:0] gpr_q [8];
    logic [WIDTH-1:0] memData_q;
    logic [15:0] limit_q;
    logic [adddp_pkg::ST_W-1:0] status_q;
    logic [adddp_pkg::ST_W-1:0] mask_q;
    logic errProt_q;
    logic errInv_q;

    // instruction length in words
    function automatic logic [16:0] instr_words(input adddp_pkg::adddp_req_type r);
        logic [16:0] n;
        n = 17'h00001;
        unique case (r.op)
            adddp_pkg::ADD_ADDRESS_REG, adddp_pkg::ADD_BYTE: n = 17'h00002;
            adddp_pkg::ADD_ADDRESS_STO:
                n = r.word0[adddp_pkg::APPEND_MODE_BIT] ? 17'h00003 : 17'h00002;
            adddp_pkg::ADD_BYTE_IMM, adddp_pkg::ADD_CARRY_REG: n = 17'h00001;
        endcase
        return n;
    endfunction

    // register number from a three-bit field
    function automatic logic [2:0] reg_field(input logic [15:0] w, input int lsb);
        return w[lsb +: 3];
    endfunction

    logic [2:0] firstReg;
    logic [2:0] secondReg;
    logic usesStorage;
    logic destStorage;
    logic byteMode;
    logic [16:0] lastFetch;
    logic [16:0] lastOperand;
    logic fetchInvalid;
    logic fetchProtect;
    logic [WIDTH-1:0] memOperand;
    logic [WIDTH-1:0] opA;
    logic [WIDTH-1:0] opB;
    logic cin;
    logic [WIDTH-1:0] sum;
    logic carryOut;
    logic overflow;
    logic [WIDTH-1:0] resBits;
    logic resNeg;
    logic resZero;
    logic commit;

    // decode of the latched instruction
    always_comb begin
        firstReg = reg_field(req_q.word0, adddp_pkg::FIRST_REG_LSB);
        secondReg = reg_field(req_q.word0, adddp_pkg::SECOND_REG_LSB);
        usesStorage = (req_q.op == adddp_pkg::ADD_ADDRESS_STO) ||
                      (req_q.op == adddp_pkg::ADD_BYTE);
        destStorage = (req_q.op == adddp_pkg::ADD_ADDRESS_STO) ||
                      ((req_q.op == adddp_pkg::ADD_BYTE) &&
                       req_q.word0[adddp_pkg::DEST_STORAGE_BIT]);
        byteMode = (req_q.op == adddp_pkg::ADD_BYTE);
    end

    // bounds against installed storage, byte addresses
    always_comb begin
        lastFetch = {1'b0, req_q.fetchAddr} +
                    17'(instr_words(req_q) * adddp_pkg::BYTES_PER_WORD) - 17'h00001;
        lastOperand = {1'b0, req_q.effAddr} + (byteMode ? 17'h00000 : 17'h00001);
        fetchInvalid = (lastFetch > {1'b0, limit_q}) ||
                       (usesStorage && (lastOperand > {1'b0, limit_q}));
        fetchProtect = req_q.problemState && req_q.fetchUnassigned;
    end

    // operand selection into the shared adder
    always_comb begin
        memOperand = (state_q == S_READ) ? memRdata : memData_q;
        opA = gpr_q[firstReg];
        opB = req_q.word1;
        cin = 1'b0;
        unique case (req_q.op)
            adddp_pkg::ADD_ADDRESS_REG: begin
                opA = gpr_q[firstReg];
                opB = req_q.word1;
            end
            adddp_pkg::ADD_ADDRESS_STO: begin
                opA = memOperand;
                // appended address word pushes the immediate to word two
                opB = req_q.word0[adddp_pkg::APPEND_MODE_BIT] ?
                      req_q.word2 : req_q.word1;
            end
            adddp_pkg::ADD_BYTE: begin
                opA = gpr_q[firstReg];
                opB = {{(WIDTH-adddp_pkg::BYTE_W){1'b0}}, memOperand[adddp_pkg::BYTE_W-1:0]};
            end
            adddp_pkg::ADD_BYTE_IMM: begin
                opA = gpr_q[firstReg];
                opB = {{(WIDTH-adddp_pkg::BYTE_W){req_q.word0[adddp_pkg::BYTE_W-1]}},
                       req_q.word0[adddp_pkg::BYTE_W-1:0]};
            end
            adddp_pkg::ADD_CARRY_REG: begin
                opA = gpr_q[secondReg];
                opB = '0;
                cin = flags.carry;
            end
        endcase
    end

    adddp_adder #(
        .WIDTH(WIDTH)
    ) u_adder (
        .a(opA),
        .b(opB),
        .cin(cin),
        .byteMode(byteMode),
        .sum(sum),
        .carryOut(carryOut),
        .overflow(overflow)
    );

    // result view for even, negative and zero
    always_comb begin
        resBits = byteMode ? {{(WIDTH-adddp_pkg::BYTE_W){1'b0}},
                              sum[adddp_pkg::BYTE_W-1:0]} : sum;
        resNeg = byteMode ? sum[adddp_pkg::BYTE_W-1] : sum[WIDTH-1];
        resZero = (resBits == '0);
        commit = (state_q == S_COMMIT) && !errProt_q && !errInv_q;
    end

    // sequencing of one instruction
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= S_IDLE;
            req_q <= '0;
            memData_q <= '0;
            errProt_q <= 1'b0;
            errInv_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (start) begin
                        req_q <= req;
                        errProt_q <= 1'b0;
                        errInv_q <= 1'b0;
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    // failing here suppresses, except a bad byte add address: nothing is modified yet
                    if (fetchProtect || fetchInvalid) begin
                        errProt_q <= fetchProtect;
                        errInv_q <= fetchInvalid;
                        state_q <= S_COMMIT;
                    end else if (usesStorage) begin
                        state_q <= S_READ;
                    end else begin
                        state_q <= S_COMMIT;
                    end
                end
                S_READ: begin
                    if (memAck) begin
                        memData_q <= memRdata;
                        if (req_q.problemState && memUnassigned) begin
                            errProt_q <= 1'b1;
                            state_q <= S_COMMIT;
                        end else if (destStorage && req_q.problemState && memReadOnly) begin
                            errProt_q <= 1'b1;
                            state_q <= S_COMMIT;
                        end else if (destStorage) begin
                            state_q <= S_WRITE;
                        end else begin
                            state_q <= S_COMMIT;
                        end
                    end
                end
                S_WRITE: begin
                    if (memAck) begin
                        state_q <= S_COMMIT;
                    end
                end
                S_COMMIT: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // storage request, held until acknowledged
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memByte <= 1'b0;
            memAddr <= '0;
            memWdata <= '0;
        end else if (state_q == S_CHECK && usesStorage && !fetchProtect && !fetchInvalid) begin
            memReq <= 1'b1;
            memWrite <= 1'b0;
            memByte <= byteMode;
            memAddr <= req_q.effAddr;
        end else if (state_q == S_READ && memAck) begin
            memReq <= destStorage && !(req_q.problemState && (memUnassigned || memReadOnly));
            memWrite <= 1'b1;
            memWdata <= byteMode ? resBits : sum;
        end else if (state_q == S_WRITE && memAck) begin
            memReq <= 1'b0;
            memWrite <= 1'b0;
        end
    end

    // general registers: datapath wins over software writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                gpr_q[i] <= '0;
            end
        end else if (commit && !destStorage) begin
            unique case (req_q.op)
                adddp_pkg::ADD_ADDRESS_REG: gpr_q[secondReg] <= sum;
                adddp_pkg::ADD_BYTE: gpr_q[firstReg] <= sum;
                adddp_pkg::ADD_BYTE_IMM: gpr_q[firstReg] <= sum;
                adddp_pkg::ADD_CARRY_REG: gpr_q[secondReg] <= sum;
                default: gpr_q[firstReg] <= gpr_q[firstReg];
            endcase
        end else if (swWrite && swAddr[adddp_pkg::GPR_BASE_BIT]) begin
            gpr_q[swAddr[2:0]] <= swWdata;
        end
    end

    // indicators follow the result of each completed add; add carry keeps even and only clears zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags <= '0;
        end else if (commit) begin
            flags.carry <= carryOut;
            flags.overflow <= overflow;
            flags.negative <= resNeg;
            if (req_q.op != adddp_pkg::ADD_CARRY_REG) begin
                flags.even <= ~resBits[0];
                flags.zero <= resZero;
            end else begin
                // multiword zero test: a clear zero never sets again
                flags.zero <= flags.zero & resZero;
            end
        end
    end

    // completion pulse and check report
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done <= 1'b0;
            check <= '0;
        end else begin
            done <= (state_q == S_COMMIT);
            if (state_q == S_COMMIT) begin
                check.protect <= errProt_q;
                check.invalidAddr <= errInv_q;
                // protect found at the operand read terminates; fetch-stage checks
                // suppress, except a bad byte add address, which always terminates
                check.terminated <= (errProt_q && !fetchProtect) ||
                                    (errInv_q && req_q.op == adddp_pkg::ADD_BYTE);
            end
        end
    end

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_q <= '0;
            mask_q <= adddp_pkg::MASK_RESET;
            limit_q <= adddp_pkg::LIMIT_RESET;
        end else begin
            status_q <= (status_q & ~((swWrite && swAddr == adddp_pkg::IDX_STATUS) ?
                                      swWdata[adddp_pkg::ST_W-1:0] : '0)) |
                        {state_q == S_COMMIT, commit && overflow,
                         state_q == S_COMMIT && errInv_q, state_q == S_COMMIT && errProt_q};
            if (swWrite && swAddr == adddp_pkg::IDX_MASK) begin
                mask_q <= swWdata[adddp_pkg::ST_W-1:0];
            end
            if (swWrite && swAddr == adddp_pkg::IDX_LIMIT) begin
                limit_q <= swWdata;
            end
        end
    end

    // read data one cycle after the strobe, zero when idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            swRdata <= '0;
        end else if (!swRead) begin
            swRdata <= '0;
        end else if (swAddr[adddp_pkg::GPR_BASE_BIT]) begin
            swRdata <= gpr_q[swAddr[2:0]];
        end else begin
            unique case (swAddr)
                adddp_pkg::IDX_STATUS: swRdata <= 16'(status_q);
                adddp_pkg::IDX_MASK: swRdata <= 16'(mask_q);
                adddp_pkg::IDX_LIMIT: swRdata <= limit_q;
                adddp_pkg::IDX_FLAGS: swRdata <= 16'(flags);
                default: swRdata <= '0;
            endcase
        end
    end

    assign busy = (state_q != S_IDLE);
    assign irq = |(status_q & mask_q);

    a_carry_word: assert property (@(posedge ref_clk) disable iff (rst)
        commit && !byteMode |=> flags.carry == $past(
            ({1'b0, opA} + {1'b0, opB} + {16'h0000, cin}) > 17'h0FFFF))
        else $error("word carry wrong");
    a_ovf_range: assert property (@(posedge ref_clk) disable iff (rst)
        commit && !byteMode |=> flags.overflow == $past(
            ($signed(opA) + $signed(opB) + $signed({1'b0, cin})) > 32767 ||
            ($signed(opA) + $signed(opB) + $signed({1'b0, cin})) < -32768))
        else $error("word overflow wrong");
    a_first_kept: assert property (@(posedge ref_clk) disable iff (rst)
        commit && req_q.op == adddp_pkg::ADD_ADDRESS_REG && firstReg != secondReg
        |=> gpr_q[$past(firstReg)] == $past(gpr_q[firstReg]) &&
            gpr_q[$past(secondReg)] == $past(sum))
        else $error("register immediate add wrong");
    a_even_kept: assert property (@(posedge ref_clk) disable iff (rst)
        commit && req_q.op == adddp_pkg::ADD_CARRY_REG |=> $stable(flags.even))
        else $error("add carry changed even");
    a_zero_clear: assert property (@(posedge ref_clk) disable iff (rst)
        commit && req_q.op == adddp_pkg::ADD_CARRY_REG && !flags.zero |=> !flags.zero)
        else $error("zero set by add carry");
    a_fetch_prot: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == S_CHECK && fetchProtect |=> ##1 done && check.protect)
        else $error("fetch protect not reported");
    a_bad_addr: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == S_CHECK && fetchInvalid |=> ##1 done && check.invalidAddr)
        else $error("invalid address not reported");
    a_suppress_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == S_CHECK && (fetchProtect || fetchInvalid) |=> !memReq [*2])
        else $error("suppressed add touched storage");
    a_ro_nowrite: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == S_READ && memAck && req_q.problemState && memReadOnly && destStorage
        |=> !memReq ##1 check.protect && check.terminated)
        else $error("read-only operand written");
endmodule
`default_nettype wire

// ### design/adddp_pkg.sv
// shared types and constants of the add instruction datapath
// Operation
// - register immediate add, first register kept
// - storage immediate add writes back storage
// - immediate after appended word when mode 1x
// - word carry from bit fifteen carry out
// - overflow cleared, set outside signed word range
// - overflow keeps low bits, carry holds sign
// - even, negative, zero follow stored result
// - byte add, bit twelve picks destination
// - byte carry and overflow use byte range
// - byte immediate sign extended then added
// - add carry indicator into second register
// - add carry keeps even, updates negative
// - add carry zero only stays or clears
// - problem state unassigned access raises protect
// - read-only operand write raises protect, terminates
// - address past installed storage raises invalid
// - suppressed leaves state, terminated may not
package adddp_pkg;
    typedef enum logic [2:0] {
        ADD_ADDRESS_REG = 3'h0,
        ADD_ADDRESS_STO = 3'h1,
        ADD_BYTE = 3'h2,
        ADD_BYTE_IMM = 3'h3,
        ADD_CARRY_REG = 3'h4
    } adddp_op_type;

    // instruction as handed over by the sequencer
    typedef struct packed {
        adddp_op_type op;
        logic [15:0] word0;
        logic [15:0] word1;
        logic [15:0] word2;
        logic [15:0] effAddr;
        logic [15:0] fetchAddr;
        logic fetchUnassigned;
        logic problemState;
    } adddp_req_type;

    typedef struct packed {
        logic protect;
        logic invalidAddr;
        logic terminated;
    } adddp_check_type;

    typedef struct packed {
        logic carry;
        logic overflow;
        logic even;
        logic negative;
        logic zero;
    } adddp_flags_type;

    // instruction fields, instruction bit 0 is word bit 15
    localparam int FIRST_REG_LSB = 8;
    localparam int SECOND_REG_LSB = 5;
    localparam int APPEND_MODE_BIT = 5;
    localparam int DEST_STORAGE_BIT = 3;
    localparam int BYTE_W = 8;
    localparam logic [16:0] BYTES_PER_WORD = 17'h00002;

    // software port map
    localparam logic [3:0] IDX_STATUS = 4'h0;
    localparam logic [3:0] IDX_MASK = 4'h1;
    localparam logic [3:0] IDX_LIMIT = 4'h2;
    localparam logic [3:0] IDX_FLAGS = 4'h3;
    localparam int GPR_BASE_BIT = 3;

    // status and mask layout
    localparam int ST_PROTECT = 0;
    localparam int ST_INVALID = 1;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_DONE = 3;
    localparam int ST_W = 4;

    localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
    localparam logic [ST_W-1:0] MASK_RESET = 4'h0;
endpackage

// ### design/adddp_adder.sv
// shared byte or word two's-complement adder
`timescale 1ns/1ps
`default_nettype none
module adddp_adder #(
    parameter int WIDTH = 16
) (
    // operands
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic cin,
    input wire logic byteMode,
    // result
    output logic [WIDTH-1:0] sum,
    output logic carryOut,
    output logic overflow
);
    localparam int H = WIDTH / 2;
    logic [WIDTH:0] full;
    logic [H:0] low;

    // separate word and low-half byte sums; byte mode keeps upper half of a
    always_comb begin
        full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
        low = {1'b0, a[H-1:0]} + {1'b0, b[H-1:0]} + {{H{1'b0}}, cin};
        if (byteMode) begin
            sum = {a[WIDTH-1:H], low[H-1:0]};
            carryOut = low[H];
            overflow = (a[H-1] == b[H-1]) && (low[H-1] != a[H-1]);
        end else begin
            sum = full[WIDTH-1:0];
            // on overflow the carry out equals the true sign
            carryOut = full[WIDTH];
            overflow = (a[WIDTH-1] == b[WIDTH-1]) && (full[WIDTH-1] != a[WIDTH-1]);
        end
    end
endmodule
`default_nettype wire

// ### tb/adddp_storage_model.sv
// behavioural main storage facing the add datapath
`timescale 1ns/1ps
`default_nettype none
module adddp_storage_model (
    // clock and answer delay in idle cycles
    input wire logic ref_clk,
    input wire logic [3:0] delay,
    // storage port
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic memByte,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWdata,
    output logic memAck,
    output logic [15:0] memRdata,
    output logic memUnassigned,
    output logic memReadOnly
);
    logic [7:0] mem [0:4095];
    logic [3:0] waitCnt;
    logic [11:0] a;
    assign a = memAddr[11:0];
    initial begin
        memAck = 1'b0;
        memRdata = 16'h0000;
        memUnassigned = 1'b0;
        memReadOnly = 1'b0;
        waitCnt = 4'h0;
    end
    // page 08 is read-only, page 09 unassigned; no ack on the ack edge itself
    always @(posedge ref_clk) begin
        if (memReq && !memAck && waitCnt == delay) begin
            memAck <= 1'b1;
            waitCnt <= 4'h0;
            memReadOnly <= memAddr[15:8] == 8'h08;
            memUnassigned <= memAddr[15:8] == 8'h09;
            memRdata <= memByte ? {8'h00, mem[a]} : {mem[a], mem[a | 12'h001]};
            if (memWrite && memByte) begin
                mem[a] <= memWdata[7:0];
            end else if (memWrite) begin
                mem[a] <= memWdata[15:8];
                mem[a | 12'h001] <= memWdata[7:0];
            end
        end else begin
            // data released: show the inverse so a stale sample is caught
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            if (memReq && !memAck) begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/test_adddp_core.sv
// self-checking bench for the add instruction datapath
`timescale 1ns/1ps
`default_nettype none
module test_adddp_core;
    logic ref_clk, rst, start, busy, done, irq, swWrite, swRead;
    logic memReq, memWrite, memByte, memAck, memUnassigned, memReadOnly;
    logic [15:0] memAddr, memWdata, memRdata, swWdata, swRdata;
    logic [3:0] swAddr, delay;
    adddp_pkg::adddp_req_type req;
    adddp_pkg::adddp_check_type check;
    adddp_pkg::adddp_flags_type flags;
    int num_errors, compares;

    adddp_core adddp_core_i (.ref_clk, .rst, .start, .req, .busy, .done, .check, .flags,
        .memReq, .memWrite, .memByte, .memAddr, .memWdata, .memAck, .memRdata,
        .memUnassigned, .memReadOnly, .swAddr, .swWdata, .swWrite, .swRead, .swRdata, .irq);
    adddp_storage_model adddp_storage_model_i (.ref_clk, .delay, .memReq, .memWrite,
        .memByte, .memAddr, .memWdata, .memAck, .memRdata, .memUnassigned, .memReadOnly);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // software port: one-cycle strobes, read data in the following cycle
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        swWrite <= 1'b1;
        swAddr <= a;
        swWdata <= d;
        @(posedge ref_clk);
        swWrite <= 1'b0;
    endtask

    task automatic cr(input logic [3:0] a, input logic [15:0] e, input string m);
        @(posedge ref_clk);
        swRead <= 1'b1;
        swAddr <= a;
        @(posedge ref_clk);
        swRead <= 1'b0;
        @(negedge ref_clk);
        chk(swRdata, e, m);
    endtask

    task automatic cf(input logic [4:0] e);
        chk({11'h000, flags}, {11'h000, e}, "indicators");
    endtask

    // one instruction; waits for done under a bound, samples at the falling edge
    task automatic run(input adddp_pkg::adddp_op_type op, input logic [15:0] w0, w1, w2,
        input logic [15:0] ea, input logic ps, fu);
        int n;
        @(posedge ref_clk);
        start <= 1'b1;
        req <= '{op, w0, w1, w2, ea, 16'h0000, fu, ps};
        @(posedge ref_clk);
        start <= 1'b0;
        @(negedge ref_clk);
        chk({15'h0000, busy}, 16'h0001, "busy while running");
        for (n = 0; n < 60 && done !== 1'b1; n++) @(negedge ref_clk);
        if (done !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: no done", $time);
            print_verdict();
        end
        chk({15'h0000, busy}, 16'h0000, "idle at done");
    endtask

    task automatic t_word();
        wr(4'h9, 16'h7FFF);
        run(adddp_pkg::ADD_ADDRESS_REG, 16'h0140, 16'h0001, 16'h0000, 16'h0000, 0, 0);
        cf(5'h0E);
        cr(4'hA, 16'h8000, "sum register");
        cr(4'h9, 16'h7FFF, "source register");
        cr(4'h3, 16'h000E, "indicator read");
        $display("word add test finished");
    endtask

    task automatic t_carry();
        wr(4'hC, 16'h0005);
        run(adddp_pkg::ADD_BYTE_IMM, 16'h04FE, 16'h0000, 16'h0000, 16'h0000, 0, 0);
        cf(5'h10);
        cr(4'hC, 16'h0003, "byte immediate sum");
        wr(4'hD, 16'hFFFF);
        // bits 5 to 7 of the instruction kept zero by the program
        run(adddp_pkg::ADD_CARRY_REG, 16'h00A0, 16'h0000, 16'h0000, 16'h0000, 0, 0);
        cf(5'h10);
        cr(4'hD, 16'h0000, "carry added");
        wr(4'hB, 16'hFFFF);
        run(adddp_pkg::ADD_ADDRESS_REG, 16'h0360, 16'h0001, 16'h0000, 16'h0000, 0, 0);
        cf(5'h15);
        run(adddp_pkg::ADD_CARRY_REG, 16'h00A0, 16'h0000, 16'h0000, 16'h0000, 0, 0);
        cf(5'h04);
        cr(4'hD, 16'h0001, "carry added again");
        $display("carry test finished");
    endtask

    task automatic t_storage();
        delay = 4'h3;
        adddp_storage_model_i.mem[12'h100] = 8'h80;
        adddp_storage_model_i.mem[12'h101] = 8'h00;
        run(adddp_pkg::ADD_ADDRESS_STO, 16'h0020, 16'hDEAD, 16'h8000, 16'h0100, 0, 0);
        cf(5'h1D);
        chk({adddp_storage_model_i.mem[12'h100], adddp_storage_model_i.mem[12'h101]},
            16'h0000, "appended form sum");
        delay = 4'h0;
        run(adddp_pkg::ADD_ADDRESS_STO, 16'h0000, 16'h0005, 16'h7777, 16'h0100, 0, 0);
        cf(5'h00);
        chk({adddp_storage_model_i.mem[12'h100], adddp_storage_model_i.mem[12'h101]},
            16'h0005, "short form sum");
        $display("storage add test finished");
    endtask

    task automatic t_byte();
        wr(4'hB, 16'hAB7F);
        adddp_storage_model_i.mem[12'h105] = 8'h01;
        run(adddp_pkg::ADD_BYTE, 16'h0300, 16'h0000, 16'h0000, 16'h0105, 0, 0);
        cf(5'h0E);
        cr(4'hB, 16'hAB80, "byte to register");
        chk({8'h00, adddp_storage_model_i.mem[12'h105]}, 16'h0001, "byte source");
        adddp_storage_model_i.mem[12'h105] = 8'h80;
        run(adddp_pkg::ADD_BYTE, 16'h0308, 16'h0000, 16'h0000, 16'h0105, 0, 0);
        cf(5'h1D);
        chk({8'h00, adddp_storage_model_i.mem[12'h105]}, 16'h0000, "byte to storage");
        cr(4'hB, 16'hAB80, "byte register kept");
        $display("byte add test finished");
    endtask

    task automatic t_checks();
        wr(4'h1, 16'h0001);
        adddp_storage_model_i.mem[12'h800] = 8'h00;
        adddp_storage_model_i.mem[12'h801] = 8'h12;
        run(adddp_pkg::ADD_ADDRESS_STO, 16'h0000, 16'h0001, 16'h0000, 16'h0800, 1, 0);
        chk({13'h0000, check}, 16'h0005, "read-only protect");
        chk({adddp_storage_model_i.mem[12'h800], adddp_storage_model_i.mem[12'h801]},
            16'h0012, "read-only word");
        cf(5'h1D);
        chk({15'h0000, irq}, 16'h0001, "interrupt raised");
        wr(4'h0, 16'h0001);
        @(negedge ref_clk);
        chk({15'h0000, irq}, 16'h0000, "interrupt cleared");
        run(adddp_pkg::ADD_ADDRESS_REG, 16'h0140, 16'h0001, 16'h0000, 16'h0000, 1, 1);
        chk({15'h0000, check.protect}, 16'h0001, "fetch protect");
        cr(4'hA, 16'h8000, "register kept");
        run(adddp_pkg::ADD_ADDRESS_REG, 16'h0140, 16'h0001, 16'h0000, 16'h0000, 0, 1);
        chk({15'h0000, check.protect}, 16'h0000, "supervisor fetch");
        wr(4'h2, 16'h00FF);
        run(adddp_pkg::ADD_ADDRESS_STO, 16'h0000, 16'h0001, 16'h0000, 16'h0200, 0, 0);
        chk({13'h0000, check}, 16'h0002, "invalid address");
        run(adddp_pkg::ADD_BYTE, 16'h0300, 16'h0000, 16'h0000, 16'h0200, 0, 0);
        chk({13'h0000, check}, 16'h0003, "byte invalid address");
        wr(4'h2, 16'hFFFF);
        run(adddp_pkg::ADD_BYTE, 16'h0300, 16'h0000, 16'h0000, 16'h0900, 1, 0);
        chk({13'h0000, check}, 16'h0005, "unassigned operand");
        cr(4'hB, 16'hAB80, "register kept on protect");
        cr(4'h5, 16'h0000, "unmapped read");
        $display("program check test finished");
    endtask

    initial begin
        rst = 1'b1;
        start = 1'b0;
        req = '0;
        swAddr = 4'h0;
        swWdata = 16'h0000;
        swWrite = 1'b0;
        swRead = 1'b0;
        delay = 4'h0;
        num_errors = 0;
        compares = 0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_word();
        t_carry();
        t_storage();
        t_byte();
        t_checks();
        print_verdict();
    end
endmodule
`default_nettype wire
